// File: logic/wdit_pkg.sv
// constants and helpers shared by the watchdog interval timer
`default_nettype none

package wdit_pkg;

    // ------------------------------------------------------------
    // register map: word indices, byte address is four times index
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_CTRL    = 3'h0;  // read control, keyed write port
    localparam logic [2:0] IDX_CNT     = 3'h1;  // read counter
    localparam logic [2:0] IDX_INIT_WR = 3'h2;  // keyed write of init control
    localparam logic [2:0] IDX_INIT_RD = 3'h3;  // read init control

    // ------------------------------------------------------------
    // write keys and access shape
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_CNT   = 8'h5a;
    localparam logic [7:0] KEY_CTRL  = 8'ha5;
    localparam logic [7:0] CLR_DATA  = 8'h00;
    localparam logic [3:0] WORD_BE   = 4'h3;   // 16-bit word in lanes 0 and 1

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         CTRL_WRAP_BIT  = 7;
    localparam int         CTRL_MODE_BIT  = 6;
    localparam int         CTRL_EN_BIT    = 5;
    localparam int         INIT_CAUSE_BIT = 7;
    localparam int         INIT_OE_BIT    = 6;
    localparam logic [1:0] CTRL_RSVD      = 2'h3;   // bits 4:3 read as one
    localparam logic [5:0] INIT_RSVD      = 6'h3f;  // bits 5:0 read as one
    localparam logic [7:0] CNT_RST        = 8'h00;
    localparam logic [7:0] CNT_TOP        = 8'hff;
    localparam logic [2:0] CKS_RST        = 3'h0;

    // ------------------------------------------------------------
    // reset pulse lengths: one state is one system clock
    // ------------------------------------------------------------
    localparam int         STATE_NS          = 10;
    localparam int         CLK_NS            = 10;
    localparam int         INT_RESET_STATES  = 518;
    localparam int         EXT_RESET_STATES  = 132;
    localparam logic [9:0] INT_RESET_CYCLES  = 10'(INT_RESET_STATES * STATE_NS / CLK_NS);
    localparam logic [9:0] EXT_RESET_CYCLES  = 10'(EXT_RESET_STATES * STATE_NS / CLK_NS);

    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } wdit_bus_e;

    // low-bit mask of the prescaler for each clock division
    function automatic logic [11:0] wdit_div_mask(input logic [2:0] sel);
        logic [11:0] m;
        m = 12'h001;
        case (sel)
            3'h0: m = 12'h001;  // /2
            3'h1: m = 12'h01f;  // /32
            3'h2: m = 12'h03f;  // /64
            3'h3: m = 12'h07f;  // /128
            3'h4: m = 12'h0ff;  // /256
            3'h5: m = 12'h1ff;  // /512
            3'h6: m = 12'h7ff;  // /2048
            default: m = 12'hfff;  // /4096
        endcase
        return m;
    endfunction : wdit_div_mask

endpackage : wdit_pkg

`default_nettype wire

// File: logic/wdit_prescaler.sv
// prescaler giving one-cycle count ticks at the selected division
`timescale 1ns/1ps
`default_nettype none

module wdit_prescaler (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output var  logic       tick_q
);

    logic [11:0] pre_q;
    logic [11:0] pre_d;
    logic        tick_d;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // held at zero while halted so the first tick after enable is a full period
    always_comb begin
        pre_d  = run ? pre_q + 12'h001 : 12'h000;
        tick_d = run && ((pre_q & wdit_pkg::wdit_div_mask(sel))
                         == wdit_pkg::wdit_div_mask(sel));
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q  <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            tick_q <= tick_d;
        end
    end

    property p_tick_one;
        @(posedge ref_clk) disable iff (!rst_n)
            (sel == 3'h0 && run && $past(run) && $past(run, 2)) |-> (tick_q != $past(tick_q));
    endproperty
    a_tick_one : assert property (p_tick_one)
        else $error("divide-by-2 tick does not alternate");

endmodule : wdit_prescaler

`default_nettype wire

// File: logic/wdit_top.sv
// watchdog and interval timer with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none

module wdit_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    output var  logic        chip_reset,
    output var  logic        system_init_output_n,
    output var  logic        interval_irq
);

    wdit_pkg::wdit_bus_e bus_q, bus_d;
    logic        wait_q,  wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic        mode_q,  mode_d;
    logic        en_q,    en_d;
    logic        wrap_q,  wrap_d;
    logic [2:0]  cks_q,   cks_d;
    logic [7:0]  cnt_q,   cnt_d;
    logic        cause_q, cause_d;
    logic        oe_q,    oe_d;
    logic        wrap_rd_q, wrap_rd_d;
    logic        cause_rd_q, cause_rd_d;
    logic [9:0]  int_cnt_q, int_cnt_d;
    logic [9:0]  ext_cnt_q, ext_cnt_d;
    logic        rst_out_q, rst_out_d;
    logic        init_n_q,  init_n_d;
    logic        irq_q,     irq_d;
    logic        tick;
    logic        accept, rd, wr, word_ok;
    logic [7:0]  key, dat;
    logic        cnt_wr, ctrl_wr, oe_wr, cause_clr_wr;
    logic        ovf, dog_ovf;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    wdit_prescaler u_pre (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (en_q),
        .sel     (cks_q),
        .tick_q  (tick)
    );

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // only a whole 16-bit word in the low lanes can carry a key
    assign accept       = (avs_read || avs_write) && wait_q;
    assign rd           = avs_read && accept;
    assign wr           = avs_write && accept;
    assign word_ok      = (avs_byteenable == wdit_pkg::WORD_BE);
    assign key          = avs_writedata[15:8];
    assign dat          = avs_writedata[7:0];
    assign cnt_wr       = wr && word_ok && !rst_out_q && (avs_address == wdit_pkg::IDX_CTRL)
                          && (key == wdit_pkg::KEY_CNT);
    assign ctrl_wr      = wr && word_ok && !rst_out_q && (avs_address == wdit_pkg::IDX_CTRL)
                          && (key == wdit_pkg::KEY_CTRL);
    assign oe_wr        = wr && word_ok && (avs_address == wdit_pkg::IDX_INIT_WR)
                          && (key == wdit_pkg::KEY_CNT);
    assign cause_clr_wr = wr && word_ok && (avs_address == wdit_pkg::IDX_INIT_WR)
                          && (key == wdit_pkg::KEY_CTRL) && (dat == wdit_pkg::CLR_DATA);
    // a counter write in the same cycle as a tick suppresses that overflow
    assign ovf          = tick && en_q && (cnt_q == wdit_pkg::CNT_TOP) && !cnt_wr;
    assign dog_ovf      = ovf && mode_q;

    // ------------------------------------------------------------
    // bus handshake: one wait cycle, then the answer
    // ------------------------------------------------------------
    always_comb begin
        bus_d   = bus_q;
        rdata_d = rdata_q;
        case (bus_q)
            wdit_pkg::BUS_IDLE: if (avs_read || avs_write) begin
                bus_d = wdit_pkg::BUS_ACK;
            end
            default: bus_d = wdit_pkg::BUS_IDLE;
        endcase
        wait_d = (bus_d == wdit_pkg::BUS_IDLE);
        // unmapped indices read as zero
        if (rd) begin
            if (avs_address == wdit_pkg::IDX_CTRL) begin
                rdata_d = {24'h000000, wrap_q, mode_q, en_q, wdit_pkg::CTRL_RSVD, cks_q};
            end else if (avs_address == wdit_pkg::IDX_CNT) begin
                rdata_d = {24'h000000, cnt_q};
            end else if (avs_address == wdit_pkg::IDX_INIT_RD) begin
                rdata_d = {24'h000000, cause_q, oe_q, wdit_pkg::INIT_RSVD};
            end else begin
                rdata_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q   <= wdit_pkg::BUS_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            bus_q   <= bus_d;
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // control, counter and wrap flag
    // ------------------------------------------------------------
    always_comb begin
        mode_d    = mode_q;
        en_d      = en_q;
        cks_d     = cks_q;
        wrap_d    = wrap_q;
        cnt_d     = cnt_q;
        wrap_rd_d = wrap_rd_q;
        if (rd && avs_address == wdit_pkg::IDX_CTRL && wrap_q) begin
            wrap_rd_d = 1'b1;
        end
        if (ctrl_wr) begin
            mode_d = dat[wdit_pkg::CTRL_MODE_BIT];
            en_d   = dat[wdit_pkg::CTRL_EN_BIT];
            cks_d  = dat[2:0];
            // flag clears only by zero after it was read as one
            if (!dat[wdit_pkg::CTRL_WRAP_BIT] && wrap_rd_q) begin
                wrap_d = 1'b0;
            end
        end
        if (cnt_wr) begin
            cnt_d = dat;
        end else if (tick && en_q) begin
            cnt_d = cnt_q + 8'h01;
        end
        if (!en_d) begin
            cnt_d = wdit_pkg::CNT_RST;
        end
        if (ovf) begin
            wrap_d = 1'b1;  // set beats clear
        end
        // internal chip reset re-initialises everything but init control
        if (rst_out_q) begin
            mode_d = 1'b0;
            en_d   = 1'b0;
            cks_d  = wdit_pkg::CKS_RST;
            wrap_d = 1'b0;
            cnt_d  = wdit_pkg::CNT_RST;
        end
        if (!wrap_d) begin
            wrap_rd_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= 1'b0;
            en_q      <= 1'b0;
            cks_q     <= wdit_pkg::CKS_RST;
            wrap_q    <= 1'b0;
            cnt_q     <= wdit_pkg::CNT_RST;
            wrap_rd_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            en_q      <= en_d;
            cks_q     <= cks_d;
            wrap_q    <= wrap_d;
            cnt_q     <= cnt_d;
            wrap_rd_q <= wrap_rd_d;
        end
    end

    // ------------------------------------------------------------
    // init control, reset pulses, interrupt
    // ------------------------------------------------------------
    // the pin reset is the async rst_n, so it overrides any pulse in flight
    always_comb begin
        cause_d    = cause_q;
        oe_d       = oe_q;
        cause_rd_d = cause_rd_q;
        if (rd && avs_address == wdit_pkg::IDX_INIT_RD && cause_q) begin
            cause_rd_d = 1'b1;
        end
        if (oe_wr) begin
            oe_d = dat[wdit_pkg::INIT_OE_BIT];
        end
        if (cause_clr_wr && cause_rd_q) begin
            cause_d = 1'b0;
        end
        if (dog_ovf) begin
            cause_d = 1'b1;
        end
        if (!cause_d) begin
            cause_rd_d = 1'b0;
        end
        int_cnt_d = (int_cnt_q != 10'h000) ? int_cnt_q - 10'h001 : 10'h000;
        ext_cnt_d = (ext_cnt_q != 10'h000) ? ext_cnt_q - 10'h001 : 10'h000;
        if (dog_ovf) begin
            int_cnt_d = wdit_pkg::INT_RESET_CYCLES;
            if (oe_q) begin
                ext_cnt_d = wdit_pkg::EXT_RESET_CYCLES;
            end
        end
        rst_out_d = (int_cnt_d != 10'h000);
        init_n_d  = (ext_cnt_d == 10'h000);
        irq_d     = wrap_d && !mode_d && en_d;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_q    <= 1'b0;
            oe_q       <= 1'b0;
            cause_rd_q <= 1'b0;
            int_cnt_q  <= 10'h000;
            ext_cnt_q  <= 10'h000;
            rst_out_q  <= 1'b0;
            init_n_q   <= 1'b1;
            irq_q      <= 1'b0;
        end else begin
            cause_q    <= cause_d;
            oe_q       <= oe_d;
            cause_rd_q <= cause_rd_d;
            int_cnt_q  <= int_cnt_d;
            ext_cnt_q  <= ext_cnt_d;
            rst_out_q  <= rst_out_d;
            init_n_q   <= init_n_d;
            irq_q      <= irq_d;
        end
    end

    assign avs_readdata         = rdata_q;
    assign avs_waitrequest      = wait_q;
    assign chip_reset           = rst_out_q;
    assign system_init_output_n = init_n_q;
    assign interval_irq         = irq_q;

    // ------------------------------------------------------------
    // checks and their helper counters
    // ------------------------------------------------------------
    logic [9:0] int_len_q;
    logic [9:0] ext_len_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_len_q <= 10'h000;
            ext_len_q <= 10'h000;
        end else begin
            int_len_q <= rst_out_q ? int_len_q + 10'h001 : 10'h000;
            ext_len_q <= !init_n_q ? ext_len_q + 10'h001 : 10'h000;
        end
    end

    sequence s_dog_ovf;
        tick && en_q && mode_q && (cnt_q == 8'hff) && !cnt_wr;
    endsequence

    sequence s_reset_starts;
        ##1 (rst_out_q && wrap_q && cause_q) ##1 (rst_out_q && !wrap_q && cause_q);
    endsequence

    property p_ovf_wrap;
        @(posedge ref_clk) disable iff (!rst_n) ovf |=> wrap_q;
    endproperty
    a_ovf_wrap : assert property (p_ovf_wrap)
        else $error("wrap flag not set on overflow");

    property p_dog_seq;
        @(posedge ref_clk) disable iff (!rst_n) s_dog_ovf |-> s_reset_starts;
    endproperty
    a_dog_seq : assert property (p_dog_seq)
        else $error("watchdog reset sequence wrong");

    property p_int_len;
        @(posedge ref_clk) disable iff (!rst_n) $fell(rst_out_q) |-> (int_len_q == 10'h206);
    endproperty
    a_int_len : assert property (p_int_len) else $error("internal reset not 518 cycles");

    property p_ext_len;
        @(posedge ref_clk) disable iff (!rst_n) $rose(init_n_q) |-> (ext_len_q == 10'h084);
    endproperty
    a_ext_len : assert property (p_ext_len) else $error("external reset not 132 cycles");

    property p_ext_gate;
        @(posedge ref_clk) disable iff (!rst_n)
            (s_dog_ovf and (!oe_q && init_n_q)) |=> init_n_q [*8];
    endproperty
    a_ext_gate : assert property (p_ext_gate)
        else $error("external reset not gated off");

    property p_cause_src;
        @(posedge ref_clk) disable iff (!rst_n) $rose(cause_q) |-> $past(dog_ovf);
    endproperty
    a_cause_src : assert property (p_cause_src)
        else $error("cause flag set without dog overflow");

    property p_irq;
        @(posedge ref_clk) disable iff (!rst_n) (ovf && !mode_q && !ctrl_wr) |=> interval_irq;
    endproperty
    a_irq : assert property (p_irq) else $error("interval interrupt missing");

    property p_write_wins;
        @(posedge ref_clk) disable iff (!rst_n)
            (cnt_wr && tick && en_q && !ctrl_wr) |=> (cnt_q == $past(avs_writedata[7:0]));
    endproperty
    a_write_wins : assert property (p_write_wins)
        else $error("tick overrode counter write");

    property p_inc;
        @(posedge ref_clk) disable iff (!rst_n)
            (tick && en_q && !cnt_wr && !ctrl_wr && !rst_out_q)
            |=> (cnt_q == $past(cnt_q) + 8'h01);
    endproperty
    a_inc : assert property (p_inc) else $error("counter did not increment");

    property p_halt_zero;
        @(posedge ref_clk) disable iff (!rst_n) !en_q |-> (cnt_q == 8'h00);
    endproperty
    a_halt_zero : assert property (p_halt_zero) else $error("halted counter not zero");

    property p_byte_ignored;
        @(posedge ref_clk) disable iff (!rst_n)
            (wr && !word_ok && !rst_out_q && !ovf && !(tick && en_q))
            |=> ($stable(cnt_q) && $stable(cks_q));
    endproperty
    a_byte_ignored : assert property (p_byte_ignored)
        else $error("byte write changed state");

endmodule : wdit_top

`default_nettype wire

// File: bench/wdit_top_tb.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none

module wdit_top_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        chip_reset;
    logic        system_init_output_n;
    logic        interval_irq;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc       = 0;
    int          divs [8]  = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    wdit_top u_wdit_top (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_writedata        (avs_writedata),
        .avs_byteenable       (avs_byteenable),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .chip_reset           (chip_reset),
        .system_init_output_n (system_init_output_n),
        .interval_irq         (interval_irq)
    );

    // ------------------------------------------------------------
    // clock and free cycle count
    // ------------------------------------------------------------
    always #5 ref_clk = ~ref_clk;
    // edge stamps only ever compared as differences
    always @(posedge ref_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // compare, verdict and bus helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // one avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic [2:0] idx, input logic wr_en, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address    <= idx;
        avs_write      <= wr_en;
        avs_read       <= ~wr_en;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            check("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
            stop_test();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [2:0] idx, input logic [7:0] key, input logic [7:0] data);
        logic [31:0] rd;
        bus(idx, 1'b1, {16'h0, key, data}, wdit_pkg::WORD_BE, rd);
    endtask : wr

    task automatic rdchk(input string name, input logic [2:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        bus(idx, 1'b0, 32'h0, 4'hf, rd);
        check(name, rd, {24'h0, exp});
    endtask : rdchk

    // bounded wait for the interrupt or the chip reset to be seen high
    task automatic wait_hi(input bit on_crst, output int t);
        int n;
        n = 0;
        while ((on_crst ? chip_reset : interval_irq) !== 1'b1 && n < 6000) begin
            @(posedge ref_clk);
            n++;
        end
        t = cyc;
        if ((on_crst ? chip_reset : interval_irq) !== 1'b1) begin
            check(on_crst ? "chip_reset_rise" : "irq_rise", 32'h0, 32'h1);
            stop_test();
        end
    endtask : wait_hi

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("chip_reset", {31'h0, chip_reset}, 32'h0);
        check("init_out_n", {31'h0, system_init_output_n}, 32'h1);
        check("irq", {31'h0, interval_irq}, 32'h0);
        rdchk("ctrl_rst", wdit_pkg::IDX_CTRL, 8'h18);
        rdchk("cnt_rst", wdit_pkg::IDX_CNT, 8'h00);
        rdchk("init_rst", wdit_pkg::IDX_INIT_RD, 8'h3f);
        rdchk("init_wr_port", wdit_pkg::IDX_INIT_WR, 8'h00);
        rdchk("unmapped", 3'h5, 8'h00);
    endtask : t_reset

    task automatic t_keys();
        logic [31:0] rd;
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h27);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'h40);
        rdchk("cnt_key", wdit_pkg::IDX_CNT, 8'h40);
        // byte write and wrong key must both leave the counter alone
        bus(wdit_pkg::IDX_CTRL, 1'b1, {16'h0, wdit_pkg::KEY_CNT, 8'h77}, 4'h1, rd);
        wr(wdit_pkg::IDX_CTRL, 8'h33, 8'h77);
        rdchk("cnt_ignored", wdit_pkg::IDX_CNT, 8'h40);
        rdchk("ctrl_key", wdit_pkg::IDX_CTRL, 8'h3f);
        // halt in the same write that changes the select, then race writes against /2 ticks
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h00);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h20);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'h10);
        // the load lands on a tick edge: 10 kept, exactly one tick since then
        rdchk("cnt_race", wdit_pkg::IDX_CNT, 8'h11);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h00);
        rdchk("cnt_halted", wdit_pkg::IDX_CNT, 8'h00);
    endtask : t_keys

    // overflow-to-overflow spacing equals the division at selects 1 to 7
    task automatic t_divs();
        logic [2:0] s;
        int         t0;
        int         t1;
        for (int i = 1; i < 8; i++) begin
            s = 3'(i);
            // after the first pass the timer still runs with the flag up
            rdchk("ctrl_arm", wdit_pkg::IDX_CTRL,
                  (i == 1) ? 8'h18 : (8'hb8 | 8'(i - 1)));
            wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, {5'h00, s});
            wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, {5'h04, s});
            wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'hff);
            wait_hi(1'b0, t0);
            rdchk("ctrl_wrap", wdit_pkg::IDX_CTRL, {5'h17, s});
            wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, {5'h04, s});
            wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'hff);
            check("irq_clear", {31'h0, interval_irq}, 32'h0);
            wait_hi(1'b0, t1);
            check("period", 32'(t1 - t0), 32'(divs[i]));
        end
        rdchk("cause_interval", wdit_pkg::IDX_INIT_RD, 8'h3f);
        rdchk("ctrl_last", wdit_pkg::IDX_CTRL, 8'hbf);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h07);
        check("irq_off", {31'h0, interval_irq}, 32'h0);
    endtask : t_divs

    // watchdog overflow: pulse lengths, gating and flag behaviour
    task automatic t_dog(input logic oe);
        int t;
        int hi;
        int lo;
        int irq;
        hi = 0;
        lo = 0;
        irq = 0;
        wr(wdit_pkg::IDX_INIT_WR, wdit_pkg::KEY_CNT, {1'b0, oe, 6'h0});
        rdchk("oe_set", wdit_pkg::IDX_INIT_RD, {1'b0, oe, 6'h3f});
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h00);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h60);
        // a reload well before the wrap must keep the chip out of reset
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'hf0);
        repeat (20) @(posedge ref_clk);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'h00);
        repeat (40) @(posedge ref_clk);
        check("dog_serviced", {31'h0, chip_reset}, 32'h0);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'hfd);
        wait_hi(1'b1, t);
        while (chip_reset === 1'b1 && hi < 1000) begin
            hi++;
            lo += (system_init_output_n === 1'b0) ? 1 : 0;
            irq += (interval_irq !== 1'b0) ? 1 : 0;
            @(posedge ref_clk);
        end
        check("chip_reset_len", 32'(hi), 32'h206);
        check("init_out_len", 32'(lo), oe ? 32'h084 : 32'h0);
        check("irq_in_dog", 32'(irq), 32'd0);
        rdchk("ctrl_after", wdit_pkg::IDX_CTRL, 8'h18);
        rdchk("cause_set", wdit_pkg::IDX_INIT_RD, {1'b1, oe, 6'h3f});
        wr(wdit_pkg::IDX_INIT_WR, wdit_pkg::KEY_CTRL, 8'h00);
        rdchk("cause_clr", wdit_pkg::IDX_INIT_RD, {1'b0, oe, 6'h3f});
    endtask : t_dog

    // pin reset arriving during the watchdog reset wins and clears the cause
    task automatic t_pin();
        int t;
        wr(wdit_pkg::IDX_INIT_WR, wdit_pkg::KEY_CNT, 8'h40);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CTRL, 8'h60);
        wr(wdit_pkg::IDX_CTRL, wdit_pkg::KEY_CNT, 8'hfd);
        wait_hi(1'b1, t);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        check("pin_chip_reset", {31'h0, chip_reset}, 32'h0);
        check("pin_init_out", {31'h0, system_init_output_n}, 32'h1);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk("pin_cause", wdit_pkg::IDX_INIT_RD, 8'h3f);
        rdchk("pin_ctrl", wdit_pkg::IDX_CTRL, 8'h18);
    endtask : t_pin

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n          = 1'b0;
        avs_address    = 3'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_keys();
        t_divs();
        t_dog(1'b1);
        t_dog(1'b0);
        t_pin();
        stop_test();
    end
endmodule : wdit_top_tb

`default_nettype wire
